// ===== include/pci_fabric_consts.svh
// Constants for the PCI core fabric port and base address setup
//
// Behaviour
// - Six 32-bit base address registers decode the PCI ranges claimed.
// - Adjacent base address registers pair up into one 64-bit register.
// - Dual-address cycles are decoded against the full 64-bit address.
// - Each register maps I/O or memory, prefetchable or not.
// - Master and target own separate FIFO paths and run independently.
// - Dual-port: both functions share one 32-bit path each direction.
// - Quad-port: each function gets its own 16-bit read and write path.
// - FIFOs accept a word every cycle until all 8 entries are full, then refuse until one drains.
// - After power-up the core answers with a default configuration space.
// - Options load from the configuration process or from the PCI bus.
// - Options and base registers read back over the PCI bus.
`ifndef PCI_FABRIC_CONSTS_SVH
`define PCI_FABRIC_CONSTS_SVH

`define BAR_NUM       6
`define FIFO_WIDTH    32
`define FIFO_DEPTH    8
`define CFG_IDX_OPT   3'h6
`define BAR_ADDR_MASK 32'hFFFF_F000
`define BAR_RESET     32'h0000_0000
`define OPT_DEFAULT   32'h0000_0000
`define OPT_IO_LSB    0
`define OPT_PREF_LSB  6
`define OPT_PAIR_LSB  12
`define BAR_IO_BIT    0
`define BAR_TYPE_LSB  1
`define BAR_PREF_BIT  3

`endif

// ===== include/pci_fabric_pkg.sv
// Types shared by the PCI core fabric port
package pci_fabric_pkg;
    typedef enum logic {FUNC_MST, FUNC_TGT} func_t;
    typedef logic [31:0] word_t;
endpackage

// ===== core/pci_fabric_port.sv
// PCI core fabric port: FIFO data paths, dual/quad packing and base address setup
`timescale 1ns/1ps
`include "pci_fabric_consts.svh"
module sync_fifo #(parameter int W = 32, parameter int D = 8) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         wr_valid,
    output logic              wr_ready,
    output logic [W-1:0]      rd_data,
    output logic              rd_valid,
    input  wire logic         rd_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic         push, pop;
    always_comb begin
        wr_ready = (wp_ff[AW] == rp_ff[AW]) || (wp_ff[AW-1:0] != rp_ff[AW-1:0]);
        rd_valid = (wp_ff != rp_ff);
        rd_data  = mem[rp_ff[AW-1:0]];
        push     = wr_valid && wr_ready;
        pop      = rd_valid && rd_ready;
        nxt_wp   = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp   = pop ? rp_ff + 1'b1 : rp_ff;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
        if (push) begin
            mem[wp_ff[AW-1:0]] <= wr_data;
        end
    end
endmodule

module pci_fabric_port (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   quad_mode,
    input  wire logic [31:0]            pci_rx_data,
    input  wire logic [1:0]             pci_rx_valid,
    output logic [1:0]                  pci_rx_ready,
    output logic [31:0]                 pci_tx_mst_data,
    output logic [31:0]                 pci_tx_tgt_data,
    output logic [1:0]                  pci_tx_valid,
    input  wire logic [1:0]             pci_tx_ready,
    output logic [31:0]                 out_data,
    output logic [1:0]                  out_valid,
    output pci_fabric_pkg::func_t       out_func,
    input  wire logic [1:0]             out_ready,
    input  wire logic [31:0]            in_data,
    input  wire logic [1:0]             in_valid,
    input  wire pci_fabric_pkg::func_t  in_func,
    output logic [1:0]                  in_ready,
    input  wire logic                   opt_load,
    input  wire logic [31:0]            opt_word,
    input  wire logic                   cfg_wr,
    input  wire logic                   cfg_rd,
    input  wire logic [2:0]             cfg_idx,
    input  wire logic [31:0]            cfg_wdata,
    output logic [31:0]                 cfg_rdata,
    output logic                        opt_loaded,
    input  wire logic [63:0]            addr,
    input  wire logic                   addr_valid,
    input  wire logic                   addr_dac,
    input  wire logic                   addr_io,
    output logic [5:0]                  bar_hit
);
    // Per-function FIFO wiring, index 0 master, 1 target
    logic [31:0] rx_dout [2], tx_din [2], tx_dout [2];
    logic [1:0]  rx_vld, rx_rdy, tx_wvld, tx_wrdy;
    genvar f;
    generate
        for (f = 0; f < 2; f++) begin : g_func
            sync_fifo #(.W(`FIFO_WIDTH), .D(`FIFO_DEPTH)) u_rx (
                .clk      (clk),
                .rst      (rst),
                .wr_data  (pci_rx_data),
                .wr_valid (pci_rx_valid[f]),
                .wr_ready (pci_rx_ready[f]),
                .rd_data  (rx_dout[f]),
                .rd_valid (rx_vld[f]),
                .rd_ready (rx_rdy[f])
            );
            sync_fifo #(.W(`FIFO_WIDTH), .D(`FIFO_DEPTH)) u_tx (
                .clk      (clk),
                .rst      (rst),
                .wr_data  (tx_din[f]),
                .wr_valid (tx_wvld[f]),
                .wr_ready (tx_wrdy[f]),
                .rd_data  (tx_dout[f]),
                .rd_valid (pci_tx_valid[f]),
                .rd_ready (pci_tx_ready[f])
            );
        end
    endgenerate
    assign pci_tx_mst_data = tx_dout[0];
    assign pci_tx_tgt_data = tx_dout[1];
    // Toward the fabric: registered output lanes
    logic [31:0]           od_ff, nxt_od;
    logic [1:0]            ov_ff, half_ff, nxt_ov, nxt_half;
    logic                  prio_ff, nxt_prio;
    pci_fabric_pkg::func_t of_ff, nxt_of;
    always_comb begin
        logic load, gsel;
        load     = 1'b0;
        gsel     = 1'b0;
        nxt_od   = od_ff;
        nxt_ov   = ov_ff;
        nxt_of   = of_ff;
        nxt_half = half_ff;
        nxt_prio = prio_ff;
        rx_rdy   = 2'b00;
        if (!quad_mode) begin
            load = !ov_ff[0] || out_ready[0];
            // Round robin only matters when both functions wait
            gsel = (rx_vld == 2'b11) ? prio_ff : rx_vld[1];
            nxt_ov[1] = 1'b0;
            if (load) begin
                nxt_ov[0] = |rx_vld;
                if (|rx_vld) begin
                    nxt_od    = rx_dout[gsel];
                    nxt_of    = pci_fabric_pkg::func_t'(gsel);
                    rx_rdy    = gsel ? 2'b10 : 2'b01;
                    nxt_prio  = ~gsel;
                end
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!ov_ff[i] || out_ready[i]) begin
                    nxt_ov[i] = rx_vld[i];
                    if (rx_vld[i]) begin
                        // Low half first, the word pops with its high half
                        nxt_od[16*i +: 16] = half_ff[i] ? rx_dout[i][31:16] : rx_dout[i][15:0];
                        nxt_half[i]        = ~half_ff[i];
                        rx_rdy[i]          = half_ff[i];
                    end
                end
            end
            nxt_of = pci_fabric_pkg::FUNC_MST;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            od_ff   <= '0;
            ov_ff   <= '0;
            of_ff   <= pci_fabric_pkg::FUNC_MST;
            half_ff <= '0;
            prio_ff <= 1'b0;
        end else begin
            od_ff   <= nxt_od;
            ov_ff   <= nxt_ov;
            of_ff   <= nxt_of;
            half_ff <= nxt_half;
            prio_ff <= nxt_prio;
        end
    end
    assign out_data  = od_ff;
    assign out_valid = ov_ff;
    assign out_func  = of_ff;
    // From the fabric: quad lanes pack two halves into one word
    logic [15:0] lo_ff [2], nxt_lo [2];
    logic [1:0]  pk_ff, nxt_pk;
    always_comb begin
        nxt_lo   = lo_ff;
        nxt_pk   = pk_ff;
        tx_wvld  = 2'b00;
        tx_din   = '{in_data, in_data};
        in_ready = 2'b00;
        if (!quad_mode) begin
            tx_wvld[in_func] = in_valid[0];
            in_ready[0]      = tx_wrdy[in_func];
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!pk_ff[i]) begin
                    in_ready[i] = 1'b1;
                    if (in_valid[i]) begin
                        nxt_lo[i] = in_data[16*i +: 16];
                        nxt_pk[i] = 1'b1;
                    end
                end else begin
                    tx_din[i]   = {in_data[16*i +: 16], lo_ff[i]};
                    tx_wvld[i]  = in_valid[i];
                    in_ready[i] = tx_wrdy[i];
                    if (in_valid[i] && tx_wrdy[i]) begin
                        nxt_pk[i] = 1'b0;
                    end
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            lo_ff <= '{16'h0000, 16'h0000};
            pk_ff <= '0;
        end else begin
            lo_ff <= nxt_lo;
            pk_ff <= nxt_pk;
        end
    end
    // Base address registers, options, readback and decode
    logic [31:0] bar_ff [`BAR_NUM], nxt_bar [`BAR_NUM], bar_view [`BAR_NUM];
    logic [31:0] opt_ff, nxt_opt, opt_eff, rdata_ff, nxt_rdata;
    logic        loaded_ff, nxt_loaded;
    logic [5:0]  hit_ff, nxt_hit;
    // Default space until options arrive
    assign opt_eff = loaded_ff ? opt_ff : `OPT_DEFAULT;
    genvar b;
    generate
        for (b = 0; b < `BAR_NUM; b++) begin : g_bar
            logic paired, is_io;
            assign paired = opt_eff[`OPT_PAIR_LSB + b/2];
            assign is_io  = opt_eff[`OPT_IO_LSB + b] && !paired;
            if (b % 2 == 0) begin : g_lo
                always_comb begin
                    bar_view[b] = bar_ff[b] & `BAR_ADDR_MASK;
                    bar_view[b][`BAR_IO_BIT] = is_io;
                    bar_view[b][`BAR_TYPE_LSB +: 2] = (paired && !is_io) ? 2'h2 : 2'h0;
                    bar_view[b][`BAR_PREF_BIT] = !is_io && opt_eff[`OPT_PREF_LSB + b];
                end
                always_comb begin
                    logic [63:0] base, a;
                    base = paired ? {bar_ff[b+1], bar_ff[b] & `BAR_ADDR_MASK}
                                  : {32'h0000_0000, bar_ff[b] & `BAR_ADDR_MASK};
                    // Single-address cycles carry a zero upper half
                    a = addr_dac ? addr : {32'h0000_0000, addr[31:0]};
                    nxt_hit[b] = addr_valid && (addr_io == is_io)
                                 && ({a[63:12], 12'h000} == base);
                end
            end else begin : g_hi
                always_comb begin
                    logic [31:0] v;
                    v = bar_ff[b] & `BAR_ADDR_MASK;
                    v[`BAR_IO_BIT] = is_io;
                    v[`BAR_PREF_BIT] = !is_io && opt_eff[`OPT_PREF_LSB + b];
                    bar_view[b] = paired ? bar_ff[b] : v;
                end
                always_comb begin
                    logic [31:0] a;
                    a = addr[31:0];
                    nxt_hit[b] = addr_valid && !paired && (addr_io == is_io)
                                 && (addr_dac ? addr[63:32] == 32'h0000_0000 : 1'b1)
                                 && ({a[31:12], 12'h000} == (bar_ff[b] & `BAR_ADDR_MASK));
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_bar    = bar_ff;
        nxt_opt    = opt_ff;
        nxt_loaded = loaded_ff;
        nxt_rdata  = rdata_ff;
        if (cfg_wr && cfg_idx < `CFG_IDX_OPT) begin
            nxt_bar[cfg_idx] = cfg_wdata;
        end
        if (cfg_wr && cfg_idx == `CFG_IDX_OPT) begin
            nxt_opt    = cfg_wdata;
            nxt_loaded = 1'b1;
        end
        // Configuration process outranks a same-cycle bus write
        if (opt_load) begin
            nxt_opt    = opt_word;
            nxt_loaded = 1'b1;
        end
        if (cfg_rd) begin
            nxt_rdata = (cfg_idx < `CFG_IDX_OPT) ? bar_view[cfg_idx]
                      : (cfg_idx == `CFG_IDX_OPT) ? opt_eff : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `BAR_NUM; i++) begin
                bar_ff[i] <= `BAR_RESET;
            end
            opt_ff    <= `OPT_DEFAULT;
            loaded_ff <= 1'b0;
            rdata_ff  <= '0;
            hit_ff    <= '0;
        end else begin
            bar_ff    <= nxt_bar;
            opt_ff    <= nxt_opt;
            loaded_ff <= nxt_loaded;
            rdata_ff  <= nxt_rdata;
            hit_ff    <= nxt_hit;
        end
    end

    assign cfg_rdata  = rdata_ff;
    assign opt_loaded = loaded_ff;
    assign bar_hit    = hit_ff;
endmodule

// ===== test/pci_fabric_port_chk.sv
// Port assertions for the fabric port
`timescale 1ns/1ps
module pci_fabric_port_chk (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  quad_mode,
    input wire logic [31:0]           out_data,
    input wire logic [1:0]            out_valid,
    input wire pci_fabric_pkg::func_t out_func,
    input wire logic [1:0]            out_ready,
    input wire logic [1:0]            in_ready,
    input wire logic                  cfg_rd,
    input wire logic [31:0]           cfg_rdata,
    input wire logic                  opt_load,
    input wire logic                  opt_loaded,
    input wire logic                  addr_valid,
    input wire logic [5:0]            bar_hit
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_clears: assert property (disable iff (1'b0) rst |=> out_valid == 2'h0 && !opt_loaded)
        else $error("reset state not clean");
    a_hit_needs_req: assert property (bar_hit != 6'h00 |-> $past(addr_valid))
        else $error("hit without request");
    a_hit_one_shot: assert property (!addr_valid |=> bar_hit == 6'h00)
        else $error("hit outlived request");
    a_dual_holds: assert property (!quad_mode && out_valid[0] && !out_ready[0]
        |=> out_valid[0] && $stable(out_data) && $stable(out_func)) else $error("dual word dropped");
    a_quad_holds: assert property (quad_mode && out_valid[1] && !out_ready[1]
        |=> out_valid[1] && $stable(out_data[31:16])) else $error("quad beat dropped");
    a_dual_one_lane: assert property (!quad_mode |-> out_valid[1] == 1'b0 && in_ready[1] == 1'b0)
        else $error("lane 1 active in dual mode");
    a_quad_func: assert property (quad_mode && out_valid != 2'h0 |-> out_func == pci_fabric_pkg::FUNC_MST)
        else $error("quad function tag set");
    a_rdata_stands: assert property (!cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved");
    a_opt_flag: assert property (opt_load || opt_loaded |=> opt_loaded)
        else $error("option flag lost");
endmodule
bind pci_fabric_port pci_fabric_port_chk chk (.clk, .rst, .quad_mode, .out_data, .out_valid, .out_func,
    .out_ready, .in_ready, .cfg_rd, .cfg_rdata, .opt_load, .opt_loaded, .addr_valid, .bar_hit);

// ===== test/fabric_model.sv
// Fabric-side sink with random stalls
`timescale 1ns/1ps
module fabric_model (
    input wire logic                  clk,
    input wire logic                  stall,
    input wire logic                  quad_mode,
    input wire logic [31:0]           out_data,
    input wire logic [1:0]            out_valid,
    input wire pci_fabric_pkg::func_t out_func,
    output logic [1:0]                out_ready
);
    logic [32:0] got0[$];
    logic [32:0] got1[$];
    initial out_ready = 2'h0;
    // Ready changes at the falling edge only, so each taken beat is unambiguous
    always @(negedge clk) out_ready <= stall ? 2'h0 : 2'($urandom_range(3));
    always @(posedge clk) begin
        if (out_valid[0] && out_ready[0]) got0.push_back(quad_mode ? {17'h0, out_data[15:0]} : {out_func, out_data});
        if (out_valid[1] && out_ready[1]) got1.push_back({17'h0, out_data[31:16]});
    end
endmodule

// ===== test/tb_pci_fabric_port.sv
// Self-checking bench for the fabric port
`timescale 1ns/1ps
module tb_pci_fabric_port;
    // Starts low so time zero gives no false falling edge to the reset count
    logic clk = 1'b0;
    logic rst, quad_mode, stall, opt_load, cfg_wr, cfg_rd, addr_valid, addr_dac, addr_io, opt_loaded, pr;
    logic [31:0] pci_rx_data, in_data, opt_word, cfg_wdata, cfg_rdata, out_data, pci_tx_mst_data, pci_tx_tgt_data;
    logic [31:0] opt, hi;
    logic [1:0] pci_rx_valid, pci_rx_ready, pci_tx_valid, out_valid, out_ready, in_valid, in_ready;
    logic [1:0] pci_tx_ready = 2'h0;
    logic [2:0] cfg_idx;
    logic [63:0] addr;
    logic [5:0] bar_hit;
    pci_fabric_pkg::func_t out_func, in_func;
    int n_errors = 0;
    int num_checks = 0;
    logic [32:0] exp0[$], exp1[$];
    logic [31:0] txq0[$], txq1[$], bar[6];

    pci_fabric_port dut (.clk, .rst, .quad_mode, .pci_rx_data, .pci_rx_valid, .pci_rx_ready, .pci_tx_mst_data,
        .pci_tx_tgt_data, .pci_tx_valid, .pci_tx_ready, .out_data, .out_valid, .out_func, .out_ready, .in_data,
        .in_valid, .in_func, .in_ready, .opt_load, .opt_word, .cfg_wr, .cfg_rd, .cfg_idx, .cfg_wdata, .cfg_rdata,
        .opt_loaded, .addr, .addr_valid, .addr_dac, .addr_io, .bar_hit);
    fabric_model fm (.clk, .stall, .quad_mode, .out_data, .out_valid, .out_func, .out_ready);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        num_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic cfg(input logic w, input logic [2:0] idx, input logic [31:0] d);
        {cfg_wr, cfg_rd, cfg_idx, cfg_wdata} = {w, !w, idx, d};
        @(negedge clk);
        {cfg_wr, cfg_rd} = 2'h0;
        @(negedge clk);
    endtask
    task automatic probe(input logic [63:0] a, input logic dac, input logic io, input logic [5:0] want);
        {addr, addr_dac, addr_io, addr_valid} = {a, dac, io, 1'b1};
        @(negedge clk);
        addr_valid = 1'b0;
        check(bar_hit, want);
        @(negedge clk);
    endtask
    function automatic logic [31:0] bar_exp(input int i);
        logic p;
        logic io;
        p = opt[12 + i / 2];
        io = !p && opt[i];
        // I/O windows carry no prefetch mark
        return (p && i % 2 == 1) ? bar[i] : {bar[i][31:12], 8'h00, opt[6 + i] && !io, p, 1'b0, io};
    endfunction
    function automatic void put_rx(input bit f, input logic [32:0] v);
        if (f) exp1.push_back(v);
        else exp0.push_back(v);
    endfunction
    function automatic void put_tx(input bit f, input logic [31:0] w);
        if (f) txq1.push_back(w);
        else txq0.push_back(w);
    endfunction
    // Word held until taken; a request still refused after 3 cycles is withdrawn
    task automatic rx_burst(input int n);
        logic [1:0] took;
        for (int k = 0; k < n; k++) begin
            pci_rx_data = $urandom;
            pci_rx_valid = 2'h3;
            for (int t = 0; t < 3; t++) begin
                #1;
                took = pci_rx_valid & pci_rx_ready;
                for (int i = 0; i < 2; i++)
                    if (took[i] && !quad_mode) put_rx(i[0], {i[0], pci_rx_data});
                    else if (took[i]) begin
                        put_rx(i[0], {17'h0, pci_rx_data[15:0]});
                        put_rx(i[0], {17'h0, pci_rx_data[31:16]});
                    end
                @(negedge clk);
                if (t == 2 || took == pci_rx_valid) break;
                pci_rx_valid = pci_rx_valid & ~took;
            end
        end
        pci_rx_valid = 2'h0;
    endtask
    task automatic in_burst(input int n);
        logic [15:0] lo[2];
        bit half[2];
        logic [1:0] took;
        half = '{1'b0, 1'b0};
        for (int k = 0; k < n; k++) begin
            in_data = $urandom;
            in_func = pci_fabric_pkg::func_t'($urandom_range(1));
            in_valid = quad_mode ? 2'h3 : 2'h1;
            for (int t = 0; t < 3; t++) begin
                #1;
                took = in_valid & in_ready;
                if (!quad_mode && took[0]) put_tx(in_func, in_data);
                for (int i = 0; i < 2; i++)
                    if (quad_mode && took[i]) begin
                        if (half[i]) put_tx(i[0], {in_data[16*i+:16], lo[i]});
                        else lo[i] = in_data[16*i+:16];
                        half[i] = !half[i];
                    end
                @(negedge clk);
                if (t == 2 || took == in_valid) break;
                in_valid = in_valid & ~took;
            end
        end
        in_valid = 2'h0;
    endtask
    task automatic match(input bit alt);
        logic [32:0] g;
        for (int t = 0; t < 400 && fm.got0.size() + fm.got1.size() < exp0.size() + exp1.size(); t++)
            @(negedge clk);
        if (alt) check({fm.got0[0][32], fm.got0[1][32]}, 64'h1);
        while (fm.got0.size() > 0) begin
            g = fm.got0.pop_front();
            check(g, g[32] ? exp1.pop_front() : exp0.pop_front());
        end
        while (fm.got1.size() > 0) check(fm.got1.pop_front(), exp1.pop_front());
        for (int t = 0; t < 400 && txq0.size() + txq1.size() > 0; t++)
            @(negedge clk);
        check(exp0.size() + exp1.size() + txq0.size() + txq1.size(), 64'h0);
    endtask

    // Far side drains at random; data is read before the edge that pops it
    always @(negedge clk) begin
        pci_tx_ready = 2'($urandom);
        #1;
        if (pci_tx_valid[0] && pci_tx_ready[0]) check(pci_tx_mst_data, txq0.pop_front());
        if (pci_tx_valid[1] && pci_tx_ready[1]) check(pci_tx_tgt_data, txq1.pop_front());
    end

    initial begin
        {quad_mode, stall, opt_load, cfg_wr, cfg_rd, addr_valid, addr_dac, addr_io, rst} = 9'h001;
        {pci_rx_data, in_data, opt_word, cfg_wdata} = 128'h0;
        {pci_rx_valid, in_valid, cfg_idx, addr} = 71'h0;
        in_func = pci_fabric_pkg::FUNC_MST;
        void'($urandom(83));
        do_reset();
        check({out_valid, bar_hit, opt_loaded, cfg_rdata}, 64'h0);
        cfg(1'b0, 3'h6, 32'h0);
        check({opt_loaded, cfg_rdata}, 64'h0);
        for (int k = 0; k < 2; k++) begin
            opt = ($urandom & 32'h7FFF) | (32'(k) << 12);
            if (k == 0) cfg(1'b1, 3'h6, opt);
            else begin
                {opt_word, opt_load} = {opt, 1'b1};
                @(negedge clk);
                opt_load = 1'b0;
            end
            cfg(1'b0, 3'h6, 32'h0);
            check({opt_loaded, cfg_rdata[14:0]}, {1'b1, opt[14:0]});
        end
        for (int i = 0; i < 6; i++) begin
            bar[i] = ($urandom & 32'hFFFF_0FFF) | (32'(i) << 12);
            cfg(1'b1, 3'(i), bar[i]);
        end
        for (int i = 0; i < 8; i++) begin
            cfg(1'b0, 3'(i), 32'h0);
            check(cfg_rdata, i < 6 ? bar_exp(i) : i == 6 ? opt : 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            pr = opt[12 + i / 2];
            hi = pr ? bar[i + 1] : 32'h0;
            if (!(pr && i % 2 == 1)) begin
                probe({hi, bar[i][31:12], 12'h5A5}, pr, !pr && opt[i], 6'(1 << i));
                probe({hi, bar[i][31:12], 12'h5A5}, pr, pr || !opt[i], 6'h00);
                if (pr) probe({hi, bar[i][31:12], 12'h5A5}, 1'b0, 1'b0, 6'h00);
            end
        end
        stall = 1'b1;
        rx_burst(12);
        check(pci_rx_ready, 64'h0);
        stall = 1'b0;
        in_burst(24);
        match(1'b1);
        quad_mode = 1'b1;
        do_reset();
        rx_burst(12);
        in_burst(24);
        match(1'b0);
        wrap_up();
    end
endmodule
